// ### axis_chk.sv
`timescale 1ns/1ns
`default_nettype none
module axis_chk (
	// Clock and causes
	input wire logic             mclk,
	input wire logic             resetn,
	input wire logic [3:0]       hw_stroke_limit,
	input wire logic             host_cpu_error,
	input wire logic [3:0]       pulse_output_end,
	input wire logic [3:0]       external_command_in,
	input wire logic [3:0][31:0] requested_speed,
	// Outputs
	input wire logic [3:0][31:0] speed_command,
	input wire logic [3:0]       stop_request,
	input wire logic [3:0]       stop_is_sudden,
	input wire logic [3:0]       positioning_done,
	input wire logic [3:0]       ext_skip_pulse
);
	// Outputs stay in reset two edges past the pin, so checks wait for that too
	logic [1:0] up_ff;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			up_ff <= 2'h0;
		end else if (!up_ff[1]) begin
			up_ff <= up_ff + 2'h1;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn || !up_ff[1]);
	a_skip_once: assert property (ext_skip_pulse[0] |=> !ext_skip_pulse[0])
		else $error("skip pulse too long");
	a_skip_cause: assert property ($rose(ext_skip_pulse[0]) |-> $past(external_command_in[0]))
		else $error("skip pulse without input");
	a_stop_limit: assert property (hw_stroke_limit[0] |=> stop_request[0])
		else $error("stroke limit did not stop");
	a_sudden_stop: assert property (stop_is_sudden[0] |-> stop_request[0])
		else $error("sudden without stop");
	a_group_two: assert property (host_cpu_error |=> &stop_request)
		else $error("host error missed an axis");
	a_speed_cap: assert property (speed_command[0] <= $past(requested_speed[0]))
		else $error("speed above request");
	a_speed_zero: assert property ($past(requested_speed[0]) == 0 |-> speed_command[0] == 0)
		else $error("speed without request");
	a_done_gap: assert property ($rose(positioning_done[0]) |-> !$past(pulse_output_end[0]))
		else $error("done too soon");
endmodule
bind axis_motion_profile_and_stop_control axis_chk axis_chk_inst (.*);
`default_nettype wire

// ### axis_motion_profile_and_stop_control.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module axis_motion_profile_and_stop_control #(
	parameter int CYC_PER_MS = motion_pkg::CYC_PER_MS
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	// AXI4-Lite slave
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Axis operating state
	input  wire logic [3:0]  jog_active,
	input  wire logic [3:0]  speed_mode_active,
	input  wire logic [3:0]  interp_member,
	input  wire logic [1:0]  interp_ref_axis,
	input  wire logic [3:0][31:0] requested_speed,
	input  wire logic [3:0]  pulse_output_end,
	// Stop causes and external command input
	input  wire logic [3:0]  hw_stroke_limit,
	input  wire logic        host_cpu_error,
	input  wire logic        controller_ready_output,
	input  wire logic        test_function_fault,
	input  wire logic [3:0]  external_stop,
	input  wire logic [3:0]  commanded_stop,
	input  wire logic [3:0]  soft_stroke_error,
	input  wire logic [3:0]  other_error,
	input  wire logic [3:0]  external_command_in,
	// Motion control outputs
	output logic [3:0][31:0] speed_command,
	output logic [3:0][31:0] accel_ramp_ms,
	output logic [3:0][31:0] decel_ramp_ms,
	output logic [3:0]       scurve_enable,
	output logic [3:0][6:0]  scurve_percent,
	output logic [3:0][16:0] arc_tolerance,
	output logic [3:0]       stop_request,
	output logic [3:0]       stop_is_sudden,
	output logic [3:0]       jog_ceiling_error,
	output logic [3:0]       positioning_done,
	output logic [3:0]       ext_start_pulse,
	output logic [3:0]       ext_speed_change_pulse,
	output logic [3:0]       ext_switch_pulse,
	output logic [3:0]       ext_skip_pulse
);
	localparam int NA = motion_pkg::NUM_AXES;
	localparam int NS = motion_pkg::NUM_SLOTS;

	logic rst_s1_ff;
	logic rst_n;

	// Reset is released through two flops so all logic leaves reset on one edge
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_ff <= 1'b0;
			rst_n     <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n     <= rst_s1_ff;
		end
	end

	function automatic logic [31:0] reset_value(input int s);
		case (s)
			motion_pkg::S_GCEIL:  reset_value = motion_pkg::RST_GCEIL;
			motion_pkg::S_JCEIL:  reset_value = motion_pkg::RST_JCEIL;
			motion_pkg::S_SRATIO: reset_value = motion_pkg::RST_SRATIO;
			motion_pkg::S_HOLD:   reset_value = motion_pkg::RST_HOLD;
			motion_pkg::S_ARC:    reset_value = motion_pkg::RST_ARC;
			motion_pkg::S_ACC0, motion_pkg::S_ACC1, motion_pkg::S_ACC2,
			motion_pkg::S_ACC3, motion_pkg::S_DEC0, motion_pkg::S_DEC1,
			motion_pkg::S_DEC2, motion_pkg::S_DEC3, motion_pkg::S_ABRUPT:
				reset_value = motion_pkg::RST_TIME;
			default: reset_value = motion_pkg::RST_ZERO;
		endcase
	endfunction

	function automatic logic [31:0] bound(input logic [31:0] v, input logic [31:0] lo,
			input logic [31:0] hi);
		bound = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// Out-of-range writes to bounded slots saturate to the nearest legal value instead of erroring; field slots keep only their low bits
	function automatic logic [31:0] legalise(input motion_pkg::slot_t s, input logic [31:0] v,
			input logic [1:0] unit);
		case (s)
			motion_pkg::S_ACC0, motion_pkg::S_ACC1, motion_pkg::S_ACC2, motion_pkg::S_ACC3,
			motion_pkg::S_DEC0, motion_pkg::S_DEC1, motion_pkg::S_DEC2, motion_pkg::S_DEC3,
			motion_pkg::S_ABRUPT:
				legalise = bound(v, motion_pkg::VAL_MIN, motion_pkg::TIME_MAX);
			motion_pkg::S_GCEIL, motion_pkg::S_JCEIL:
				legalise = bound(v, motion_pkg::VAL_MIN, (unit == motion_pkg::UNIT_PULSE)
					? motion_pkg::PULSE_MAX : motion_pkg::SPEED_MAX);
			motion_pkg::S_SRATIO:
				legalise = bound(v, motion_pkg::VAL_MIN, motion_pkg::RATIO_MAX);
			motion_pkg::S_ARC:
				legalise = bound(v, motion_pkg::RST_ZERO, motion_pkg::ARC_MAX);
			motion_pkg::S_UNIT, motion_pkg::S_JACC, motion_pkg::S_JDEC, motion_pkg::S_EXTF:
				legalise = {30'h0000_0000, v[1:0]};
			motion_pkg::S_PROF, motion_pkg::S_GRP1, motion_pkg::S_GRP2, motion_pkg::S_GRP3,
			motion_pkg::S_CTRL:
				legalise = {31'h0000_0000, v[0]};
			motion_pkg::S_HOLD, motion_pkg::S_DWELL:
				legalise = {16'h0000, v[15:0]};
			default: legalise = motion_pkg::RST_ZERO;
		endcase
	endfunction

	function automatic motion_pkg::slot_t idx_to_slot(input logic [7:0] i);
		case (i)
			motion_pkg::IDX_UNIT:   idx_to_slot = motion_pkg::S_UNIT;
			motion_pkg::IDX_GCEIL:  idx_to_slot = motion_pkg::S_GCEIL;
			motion_pkg::IDX_ACC0:   idx_to_slot = motion_pkg::S_ACC0;
			motion_pkg::IDX_DEC0:   idx_to_slot = motion_pkg::S_DEC0;
			motion_pkg::IDX_ACC1:   idx_to_slot = motion_pkg::S_ACC1;
			motion_pkg::IDX_ACC2:   idx_to_slot = motion_pkg::S_ACC2;
			motion_pkg::IDX_ACC3:   idx_to_slot = motion_pkg::S_ACC3;
			motion_pkg::IDX_DEC1:   idx_to_slot = motion_pkg::S_DEC1;
			motion_pkg::IDX_DEC2:   idx_to_slot = motion_pkg::S_DEC2;
			motion_pkg::IDX_DEC3:   idx_to_slot = motion_pkg::S_DEC3;
			motion_pkg::IDX_JCEIL:  idx_to_slot = motion_pkg::S_JCEIL;
			motion_pkg::IDX_JACC:   idx_to_slot = motion_pkg::S_JACC;
			motion_pkg::IDX_JDEC:   idx_to_slot = motion_pkg::S_JDEC;
			motion_pkg::IDX_PROF:   idx_to_slot = motion_pkg::S_PROF;
			motion_pkg::IDX_SRATIO: idx_to_slot = motion_pkg::S_SRATIO;
			motion_pkg::IDX_ABRUPT: idx_to_slot = motion_pkg::S_ABRUPT;
			motion_pkg::IDX_GRP1:   idx_to_slot = motion_pkg::S_GRP1;
			motion_pkg::IDX_GRP2:   idx_to_slot = motion_pkg::S_GRP2;
			motion_pkg::IDX_GRP3:   idx_to_slot = motion_pkg::S_GRP3;
			motion_pkg::IDX_HOLD:   idx_to_slot = motion_pkg::S_HOLD;
			motion_pkg::IDX_ARC:    idx_to_slot = motion_pkg::S_ARC;
			motion_pkg::IDX_EXTF:   idx_to_slot = motion_pkg::S_EXTF;
			motion_pkg::IDX_DWELL:  idx_to_slot = motion_pkg::S_DWELL;
			motion_pkg::IDX_CTRL:   idx_to_slot = motion_pkg::S_CTRL;
			motion_pkg::IDX_STATUS: idx_to_slot = motion_pkg::S_STATUS;
			default:                idx_to_slot = motion_pkg::S_NONE;
		endcase
	endfunction

	// Splits a byte address into axis and slot; each axis block is one stride apart
	function automatic logic [6:0] decode(input logic [11:0] addr);
		logic [11:0] word;
		logic [11:0] local_idx;
		logic [1:0]  axis;
		word      = {2'h0, addr[11:2]};
		axis      = 2'h3;
		local_idx = word - 12'(3 * motion_pkg::AXIS_STRIDE);
		if (word < motion_pkg::AXIS_STRIDE) begin
			axis      = 2'h0;
			local_idx = word;
		end else if (word < 12'(2 * motion_pkg::AXIS_STRIDE)) begin
			axis      = 2'h1;
			local_idx = word - motion_pkg::AXIS_STRIDE;
		end else if (word < 12'(3 * motion_pkg::AXIS_STRIDE)) begin
			axis      = 2'h2;
			local_idx = word - 12'(2 * motion_pkg::AXIS_STRIDE);
		end
		if (local_idx > 12'h0FF) begin
			decode = {axis, motion_pkg::S_NONE};
		end else begin
			decode = {axis, idx_to_slot(local_idx[7:0])};
		end
	endfunction

	logic [31:0] regs_ff [NA][NS];
	logic [31:0] nxt_regs [NA][NS];
	logic        aw_full_ff, w_full_ff, bvalid_ff, rvalid_ff;
	logic        nxt_aw_full, nxt_w_full, nxt_bvalid, nxt_rvalid;
	logic [11:0] aw_addr_ff, nxt_aw_addr;
	logic [31:0] w_data_ff, nxt_w_data, rdata_ff, nxt_rdata;
	logic [3:0]  w_strb_ff, nxt_w_strb;
	logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [3:0]  jog_err;

	// Readies stay low while held in reset, so an early request is never shown as taken
	assign s_axi_awready = rst_n && !aw_full_ff;
	assign s_axi_wready  = rst_n && !w_full_ff;
	assign s_axi_arready = rst_n && !rvalid_ff;

	always_comb begin
		logic [6:0]  wdec;
		logic [6:0]  rdec;
		logic [31:0] mask;
		logic [31:0] merged;
		logic [1:0]  wa;
		logic [1:0]  ra;
		motion_pkg::slot_t ws;
		motion_pkg::slot_t rs;
		wdec = decode(aw_addr_ff);
		rdec = decode(s_axi_araddr);
		wa   = wdec[6:5];
		ra   = rdec[6:5];
		ws   = motion_pkg::slot_t'(wdec[4:0]);
		rs   = motion_pkg::slot_t'(rdec[4:0]);
		mask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
		merged      = motion_pkg::RST_ZERO;
		nxt_regs    = regs_ff;
		nxt_aw_full = aw_full_ff;
		nxt_aw_addr = aw_addr_ff;
		nxt_w_full  = w_full_ff;
		nxt_w_data  = w_data_ff;
		nxt_w_strb  = w_strb_ff;
		nxt_bvalid  = bvalid_ff && !s_axi_bready;
		nxt_bresp   = bresp_ff;
		nxt_rvalid  = rvalid_ff && !s_axi_rready;
		nxt_rdata   = rdata_ff;
		nxt_rresp   = rresp_ff;
		if (s_axi_awvalid && !aw_full_ff) begin
			nxt_aw_full = 1'b1;
			nxt_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_full_ff) begin
			nxt_w_full = 1'b1;
			nxt_w_data = s_axi_wdata;
			nxt_w_strb = s_axi_wstrb;
		end
		if (aw_full_ff && w_full_ff && !bvalid_ff) begin
			nxt_aw_full = 1'b0;
			nxt_w_full  = 1'b0;
			nxt_bvalid  = 1'b1;
			nxt_bresp   = (ws == motion_pkg::S_NONE) ? motion_pkg::RESP_SLVERR
				: motion_pkg::RESP_OKAY;
			if (ws != motion_pkg::S_NONE && ws != motion_pkg::S_STATUS) begin
				merged = (regs_ff[wa][ws] & ~mask) | (w_data_ff & mask);
				nxt_regs[wa][ws] = legalise(ws, merged, regs_ff[wa][motion_pkg::S_UNIT][1:0]);
			end
		end
		if (s_axi_arvalid && !rvalid_ff) begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = (rs == motion_pkg::S_NONE) ? motion_pkg::RESP_SLVERR
				: motion_pkg::RESP_OKAY;
			if (rs == motion_pkg::S_NONE) begin
				nxt_rdata = motion_pkg::RST_ZERO;
			end else if (rs == motion_pkg::S_STATUS) begin
				nxt_rdata = {16'h0000, jog_err[ra] ? motion_pkg::ERR_JOG_CEIL : 16'h0000};
			end else begin
				nxt_rdata = regs_ff[ra][rs];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int a = 0; a < NA; a++) begin
				for (int s = 0; s < NS; s++) begin
					regs_ff[a][s] <= reset_value(s);
				end
			end
			aw_full_ff <= 1'b0;
			aw_addr_ff <= 12'h000;
			w_full_ff  <= 1'b0;
			w_data_ff  <= 32'h0000_0000;
			w_strb_ff  <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= 2'h0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= 2'h0;
		end else begin
			regs_ff    <= nxt_regs;
			aw_full_ff <= nxt_aw_full;
			aw_addr_ff <= nxt_aw_addr;
			w_full_ff  <= nxt_w_full;
			w_data_ff  <= nxt_w_data;
			w_strb_ff  <= nxt_w_strb;
			bvalid_ff  <= nxt_bvalid;
			bresp_ff   <= nxt_bresp;
			rvalid_ff  <= nxt_rvalid;
			rdata_ff   <= nxt_rdata;
			rresp_ff   <= nxt_rresp;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;

	// Shared millisecond time base for all axes
	logic [31:0] ms_cnt_ff, nxt_ms_cnt;
	logic        ms_tick;

	always_comb begin
		ms_tick    = (ms_cnt_ff == 32'(CYC_PER_MS - 1));
		nxt_ms_cnt = ms_tick ? 32'h0000_0000 : ms_cnt_ff + 32'h0000_0001;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt_ff <= 32'h0000_0000;
		end else begin
			ms_cnt_ff <= nxt_ms_cnt;
		end
	end

	logic [3:0] ext_prev_ff;
	logic [3:0] ext_edge;
	assign ext_edge = external_command_in & ~ext_prev_ff;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ext_prev_ff <= 4'h0;
		end else begin
			ext_prev_ff <= external_command_in;
		end
	end

	// Group two causes are module-wide and hit every axis at once
	logic grp2_cause;
	assign grp2_cause = host_cpu_error || !controller_ready_output || test_function_fault;

	for (genvar a = 0; a < NA; a++) begin : g_axis
		logic [31:0] ceil, nxt_speed, nxt_acc, nxt_dec;
		logic        g1, g3, nxt_req, nxt_sudden;
		logic [3:0]  nxt_ext;
		logic [3:0]  ext_ff;
		logic [31:0] speed_ff, acc_ff, dec_ff;
		logic        req_ff, sudden_ff;
		logic [15:0] hold_sel;

		assign jog_err[a] = regs_ff[a][motion_pkg::S_JCEIL] > regs_ff[a][motion_pkg::S_GCEIL];

		always_comb begin
			g1 = hw_stroke_limit[a];
			g3 = external_stop[a] || commanded_stop[a] || other_error[a]
				|| (soft_stroke_error[a] && (jog_active[a] || speed_mode_active[a]));
			nxt_req    = g1 || grp2_cause || g3;
			nxt_sudden = (g1 && regs_ff[a][motion_pkg::S_GRP1][0] == motion_pkg::STOP_SUDDEN)
				|| (grp2_cause && regs_ff[a][motion_pkg::S_GRP2][0] == motion_pkg::STOP_SUDDEN)
				|| (g3 && regs_ff[a][motion_pkg::S_GRP3][0] == motion_pkg::STOP_SUDDEN);
			ceil = jog_active[a] ? regs_ff[a][motion_pkg::S_JCEIL]
				: regs_ff[a][motion_pkg::S_GCEIL];
			nxt_speed = (requested_speed[a] > ceil) ? ceil : requested_speed[a];
			if (jog_active[a]) begin
				nxt_acc = regs_ff[a][motion_pkg::S_ACC0];
				case (regs_ff[a][motion_pkg::S_JACC][1:0])
					2'h1:    nxt_acc = regs_ff[a][motion_pkg::S_ACC1];
					2'h2:    nxt_acc = regs_ff[a][motion_pkg::S_ACC2];
					2'h3:    nxt_acc = regs_ff[a][motion_pkg::S_ACC3];
					default: nxt_acc = regs_ff[a][motion_pkg::S_ACC0];
				endcase
				case (regs_ff[a][motion_pkg::S_JDEC][1:0])
					2'h1:    nxt_dec = regs_ff[a][motion_pkg::S_DEC1];
					2'h2:    nxt_dec = regs_ff[a][motion_pkg::S_DEC2];
					2'h3:    nxt_dec = regs_ff[a][motion_pkg::S_DEC3];
					default: nxt_dec = regs_ff[a][motion_pkg::S_DEC0];
				endcase
			end else begin
				nxt_acc = regs_ff[a][motion_pkg::S_ACC0];
				nxt_dec = regs_ff[a][motion_pkg::S_DEC0];
			end
			if (nxt_req && nxt_sudden) begin
				nxt_dec = regs_ff[a][motion_pkg::S_ABRUPT];
			end
			// Edges arriving while the input is disabled are dropped, not queued
			nxt_ext = 4'h0;
			if (ext_edge[a] && regs_ff[a][motion_pkg::S_CTRL][0]) begin
				nxt_ext[regs_ff[a][motion_pkg::S_EXTF][1:0]] = 1'b1;
			end
		end

		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				speed_ff  <= 32'h0000_0000;
				acc_ff    <= motion_pkg::RST_TIME;
				dec_ff    <= motion_pkg::RST_TIME;
				req_ff    <= 1'b0;
				sudden_ff <= 1'b0;
				ext_ff    <= 4'h0;
			end else begin
				speed_ff  <= nxt_speed;
				acc_ff    <= nxt_acc;
				dec_ff    <= nxt_dec;
				req_ff    <= nxt_req;
				sudden_ff <= nxt_sudden;
				ext_ff    <= nxt_ext;
			end
		end

		assign speed_command[a]          = speed_ff;
		assign accel_ramp_ms[a]          = acc_ff;
		assign decel_ramp_ms[a]          = dec_ff;
		assign stop_request[a]           = req_ff;
		assign stop_is_sudden[a]         = sudden_ff;
		assign jog_ceiling_error[a]      = jog_err[a];
		assign scurve_enable[a]          =
			regs_ff[a][motion_pkg::S_PROF][0] == motion_pkg::PROF_SCURVE;
		assign scurve_percent[a]         = regs_ff[a][motion_pkg::S_SRATIO][6:0];
		assign arc_tolerance[a]          = regs_ff[a][motion_pkg::S_ARC][16:0];
		assign ext_start_pulse[a]        = ext_ff[motion_pkg::EXT_START];
		assign ext_speed_change_pulse[a] = ext_ff[motion_pkg::EXT_SPEED];
		assign ext_switch_pulse[a]       = ext_ff[motion_pkg::EXT_SWITCH];
		assign ext_skip_pulse[a]         = ext_ff[motion_pkg::EXT_SKIP];

		assign hold_sel = interp_member[a] ? regs_ff[interp_ref_axis][motion_pkg::S_HOLD][15:0]
			: regs_ff[a][motion_pkg::S_HOLD][15:0];

		completion_timer completion_timer_inst (
			.mclk      (mclk),
			.rst_n     (rst_n),
			.ms_tick   (ms_tick),
			.pulse_end (pulse_output_end[a]),
			.dwell_ms  (regs_ff[a][motion_pkg::S_DWELL][15:0]),
			.hold_ms   (hold_sel),
			.done      (positioning_done[a])
		);
	end
endmodule
`default_nettype wire

// ### axis_motion_profile_and_stop_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module axis_motion_profile_and_stop_control_tb;
	logic mclk = 0, resetn = 0, host_cpu_error = 0, controller_ready_output = 1;
	logic test_function_fault = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, interp_ref_axis = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb = 4'hF, jog_active = 0, speed_mode_active = 0, interp_member = 0;
	logic [3:0] hw_stroke_limit = 0, external_stop = 0, commanded_stop = 0, soft_stroke_error = 0;
	logic [3:0] other_error = 0, external_command_in = 0, pulse_output_end, scurve_enable;
	logic [3:0] stop_request, stop_is_sudden, jog_ceiling_error, positioning_done, ext_start_pulse;
	logic [3:0] ext_speed_change_pulse, ext_switch_pulse, ext_skip_pulse;
	logic [3:0][31:0] requested_speed = 0, speed_command, accel_ramp_ms, decel_ramp_ms;
	logic [3:0][6:0] scurve_percent;
	logic [3:0][16:0] arc_tolerance;
	logic [7:0] ri[8] = '{8'h34, 8'h35, 8'h36, 8'h38, 8'h3A, 8'h3B, 8'h3C, 8'h3E};
	logic [31:0] re[8] = '{32'h0, 32'h64, 32'h3E8, 32'h0, 32'h0, 32'h12C, 32'h64, 32'h0};
	int n_errors = 0, checks_done = 0;
	always #5 mclk = ~mclk;
	axis_motion_profile_and_stop_control #(.CYC_PER_MS(10))
		axis_motion_profile_and_stop_control_inst (.*);
	drive_model drive_model_inst (.*);
	task automatic conclude;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic ck(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic till(ref logic s);
		int i;
		i = 0;
		do @(negedge mclk); while (s !== 1'b1 && ++i < 200);
		if (s !== 1'b1) begin
			n_errors++;
			conclude();
		end
	endtask
	task automatic wr(input int ax, input logic [7:0] ix, input logic [31:0] d);
		@(posedge mclk);
		s_axi_awaddr <= 12'((ax * 150 + ix) * 4);
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		till(s_axi_awready);
		@(posedge mclk);
		{s_axi_awvalid, s_axi_wvalid} <= 2'h0;
		till(s_axi_bvalid);
		@(posedge mclk);
		s_axi_bready <= 0;
	endtask
	task automatic rd(input int ax, input logic [7:0] ix);
		@(posedge mclk);
		s_axi_araddr <= 12'((ax * 150 + ix) * 4);
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		till(s_axi_arready);
		@(posedge mclk);
		s_axi_arvalid <= 0;
		till(s_axi_rvalid);
		@(posedge mclk);
		{rv, rr} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 0;
	endtask
	// Input held several cycles so a late pulse is still caught
	task automatic ext(input logic [3:0] e);
		logic [3:0] h;
		h = 4'h0;
		@(posedge mclk);
		external_command_in[0] <= 1;
		repeat (4) begin
			@(negedge mclk);
			h |= {ext_skip_pulse[0], ext_switch_pulse[0], ext_speed_change_pulse[0], ext_start_pulse[0]};
		end
		@(posedge mclk);
		external_command_in[0] <= 0;
		ck("ext func", h, e);
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		resetn <= 1;
		repeat (3) @(posedge mclk);
		for (int i = 0; i < 8; i++) begin
			rd(0, ri[i]);
			ck("default", rv, re[i]);
		end
		wr(1, 8'h35, 32'h0);
		rd(1, 8'h35);
		ck("ratio floor", rv, 32'h1);
		rd(0, 8'h35);
		ck("axis copy", rv, 32'h64);
		rd(5, 8'h00);
		ck("unmapped", rr, 32'h2);
		jog_active[0] <= 1;
		requested_speed[0] <= 32'hC350;
		repeat (3) @(negedge mclk);
		ck("jog cap", speed_command[0], 32'h4E20);
		wr(0, 8'h30, 32'h493E0);
		rd(0, 8'h42);
		ck("err code", rv, 32'h3BC);
		ck("err flag", jog_ceiling_error[0], 32'h1);
		ext(4'h0);
		wr(0, 8'h41, 32'h1);
		for (int c = 0; c < 4; c++) begin
			wr(0, 8'h3E, 32'(c));
			ext(4'h1 << c);
		end
		wr(0, 8'h24, 32'h5DC);
		wr(0, 8'h32, 32'h1);
		wr(0, 8'h2A, 32'h7D0);
		wr(0, 8'h33, 32'h1);
		@(negedge mclk);
		ck("jog accel", accel_ramp_ms[0], 32'h5DC);
		ck("jog decel", decel_ramp_ms[0], 32'h7D0);
		wr(0, 8'h34, 32'h1);
		ck("s-curve", {scurve_enable[0], scurve_percent[0]}, 32'hE4);
		ck("arc", arc_tolerance[0], 32'h64);
		wr(0, 8'h36, 32'h1F4);
		wr(0, 8'h38, 32'h1);
		wr(0, 8'h3B, 32'h2);
		@(posedge mclk);
		hw_stroke_limit[0] <= 1;
		repeat (2) @(negedge mclk);
		ck("sudden", {stop_request[0], stop_is_sudden[0]}, 32'h3);
		ck("sudden ramp", decel_ramp_ms[0], 32'h1F4);
		repeat (8) @(negedge mclk);
		ck("done on", positioning_done[0], 32'h1);
		repeat (40) @(negedge mclk);
		ck("done off", positioning_done[0], 32'h0);
		@(posedge mclk);
		host_cpu_error <= 1;
		interp_member[1] <= 1;
		repeat (2) @(negedge mclk);
		ck("group two", stop_request, 32'hF);
		repeat (8) @(negedge mclk);
		ck("ref hold on", positioning_done[1], 32'h1);
		repeat (40) @(negedge mclk);
		ck("ref hold off", positioning_done[1], 32'h0);
		conclude();
	end
endmodule
`default_nettype wire

// ### completion_timer.sv
`timescale 1ns/1ns
`default_nettype none
module completion_timer (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Time base and events
	input  wire logic        ms_tick,
	input  wire logic        pulse_end,
	input  wire logic [15:0] dwell_ms,
	input  wire logic [15:0] hold_ms,
	// Result
	output logic             done
);
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_DWELL = 3'b010,
		ST_HOLD  = 3'b100
	} tstate_t;

	tstate_t     state_ff;
	tstate_t     nxt_state;
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic        done_ff;
	logic        nxt_done;

	// Times count whole ms ticks, so each span may end up to one tick early
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_done  = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if (pulse_end) begin
					nxt_state = ST_DWELL;
					nxt_cnt   = 16'h0000;
				end
			end
			ST_DWELL: begin
				if (cnt_ff >= dwell_ms) begin
					nxt_cnt   = 16'h0000;
					nxt_state = (hold_ms == 16'h0000) ? ST_IDLE : ST_HOLD;
					nxt_done  = (hold_ms != 16'h0000);
				end else if (ms_tick) begin
					nxt_cnt = cnt_ff + 16'h0001;
				end
			end
			ST_HOLD: begin
				nxt_done = 1'b1;
				if (ms_tick) begin
					nxt_cnt = cnt_ff + 16'h0001;
				end
				if (pulse_end) begin
					nxt_state = ST_DWELL;
					nxt_cnt   = 16'h0000;
					nxt_done  = 1'b0;
				end else if (ms_tick && (cnt_ff + 16'h0001 >= hold_ms)) begin
					nxt_state = ST_IDLE;
					nxt_done  = 1'b0;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			cnt_ff   <= 16'h0000;
			done_ff  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			done_ff  <= nxt_done;
		end
	end

	assign done = done_ff;
endmodule
`default_nettype wire

// ### drive_model.sv
`timescale 1ns/1ns
`default_nettype none
module drive_model (
	// Clock and stop
	input wire logic       mclk,
	input wire logic [3:0] stop_request,
	// Motion finished
	output logic [3:0]     pulse_output_end
);
	// Drive halts two cycles after a stop and reports its pulse train end once
	logic [3:0] s1_ff, s2_ff;
	always_ff @(posedge mclk) begin
		s1_ff <= stop_request;
		s2_ff <= s1_ff;
		pulse_output_end <= s1_ff & ~s2_ff;
	end
endmodule
`default_nettype wire

// ### motion_pkg.sv
`default_nettype none
package motion_pkg;
	// Clock and time base
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS         = 1000000;
	localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

	// Axis layout: word index = axis * AXIS_STRIDE + register index, byte = 4 * word
	localparam int          NUM_AXES    = 4;
	localparam logic [11:0] AXIS_STRIDE = 12'h096;

	// Register indices within one axis block
	localparam logic [7:0] IDX_UNIT     = 8'h01;
	localparam logic [7:0] IDX_GCEIL    = 8'h0A;
	localparam logic [7:0] IDX_ACC0     = 8'h0C;
	localparam logic [7:0] IDX_DEC0     = 8'h0D;
	localparam logic [7:0] IDX_ACC1     = 8'h24;
	localparam logic [7:0] IDX_ACC2     = 8'h26;
	localparam logic [7:0] IDX_ACC3     = 8'h28;
	localparam logic [7:0] IDX_DEC1     = 8'h2A;
	localparam logic [7:0] IDX_DEC2     = 8'h2C;
	localparam logic [7:0] IDX_DEC3     = 8'h2E;
	localparam logic [7:0] IDX_JCEIL    = 8'h30;
	localparam logic [7:0] IDX_JACC     = 8'h32;
	localparam logic [7:0] IDX_JDEC     = 8'h33;
	localparam logic [7:0] IDX_PROF     = 8'h34;
	localparam logic [7:0] IDX_SRATIO   = 8'h35;
	localparam logic [7:0] IDX_ABRUPT   = 8'h36;
	localparam logic [7:0] IDX_GRP1     = 8'h38;
	localparam logic [7:0] IDX_GRP2     = 8'h39;
	localparam logic [7:0] IDX_GRP3     = 8'h3A;
	localparam logic [7:0] IDX_HOLD     = 8'h3B;
	localparam logic [7:0] IDX_ARC      = 8'h3C;
	localparam logic [7:0] IDX_EXTF     = 8'h3E;
	localparam logic [7:0] IDX_DWELL    = 8'h40;
	localparam logic [7:0] IDX_CTRL     = 8'h41;
	localparam logic [7:0] IDX_STATUS   = 8'h42;

	// Storage slots
	typedef enum logic [4:0] {
		S_UNIT, S_GCEIL, S_ACC0, S_DEC0, S_ACC1, S_ACC2, S_ACC3, S_DEC1, S_DEC2,
		S_DEC3, S_JCEIL, S_JACC, S_JDEC, S_PROF, S_SRATIO, S_ABRUPT, S_GRP1,
		S_GRP2, S_GRP3, S_HOLD, S_ARC, S_EXTF, S_DWELL, S_CTRL, S_STATUS, S_NONE
	} slot_t;
	localparam int NUM_SLOTS = 25;

	// Reset values
	localparam logic [31:0] RST_TIME   = 32'h0000_03E8;
	localparam logic [31:0] RST_GCEIL  = 32'h0003_0D40;
	localparam logic [31:0] RST_JCEIL  = 32'h0000_4E20;
	localparam logic [31:0] RST_SRATIO = 32'h0000_0064;
	localparam logic [31:0] RST_HOLD   = 32'h0000_012C;
	localparam logic [31:0] RST_ARC    = 32'h0000_0064;
	localparam logic [31:0] RST_ZERO   = 32'h0000_0000;

	// Legal ranges
	localparam logic [31:0] TIME_MAX   = 32'h0080_0000;
	localparam logic [31:0] SPEED_MAX  = 32'h7735_9400;
	localparam logic [31:0] PULSE_MAX  = 32'h003D_0900;
	localparam logic [31:0] RATIO_MAX  = 32'h0000_0064;
	localparam logic [31:0] ARC_MAX    = 32'h0001_86A0;
	localparam logic [31:0] VAL_MIN    = 32'h0000_0001;
	localparam logic [1:0]  UNIT_PULSE = 2'h3;

	// Codes
	localparam logic [15:0] ERR_JOG_CEIL = 16'h03BC;
	localparam logic [1:0]  EXT_START    = 2'h0;
	localparam logic [1:0]  EXT_SPEED    = 2'h1;
	localparam logic [1:0]  EXT_SWITCH   = 2'h2;
	localparam logic [1:0]  EXT_SKIP     = 2'h3;
	localparam logic        PROF_SCURVE  = 1'b1;
	localparam logic        STOP_SUDDEN  = 1'b1;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire
